// >>> fbd_pkg.sv
// Summary of operation
// - Read: select low, output enable low, write high
// - Write: strobe and select low, output enable high
// - Address 18..0 word, 18..-1 byte
// - Protect: elevated reset, A1 high, A0 low, A6 selects
package fbd_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // Bus cycle phase lengths in ns at a 10 ns clock
  localparam int CLK_NS        = 10;
  localparam int ACCESS_NS     = 150;
  localparam int WRITE_NS      = 60;
  localparam int RESET_NS      = 500;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC     = (WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC     = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 8;

  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [18:0] ADDR_RST = 19'h00000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // Protect selection address bits
  localparam int PROT_A6 = 6;
  localparam int PROT_A1 = 1;
  localparam int PROT_A0 = 0;

  typedef enum logic [1:0]
  {
    OP_READ    = 2'h0,
    OP_WRITE   = 2'h1,
    OP_PROTECT = 2'h2,
    OP_RESET   = 2'h3
  } fbd_op_type;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_HOLD  = 3'b011,
    ST_DONE  = 3'b010,
    ST_RST   = 3'b110
  } fbd_state_type;

  typedef struct packed
  {
    fbd_op_type  op;
    logic        byte_mode;
    logic        byte_lsb;
    logic        unprotect;
    logic [18:0] addr;
    logic [15:0] wdata;
  } fbd_req_type;

  typedef struct packed
  {
    logic        chip_sel_n;
    logic        out_en_n;
    logic        wr_en_n;
    logic        reset_n;
    logic        elevated_voltage_level;
    logic        byte_sel_n;
    logic [18:0] addr;
  } fbd_pins_type;

  function automatic logic [CNT_W-1:0] fbd_cyc(input int n);
    fbd_cyc = CNT_W'(n - 1);
  endfunction : fbd_cyc

endpackage : fbd_pkg

// >>> fbd_host.sv
`timescale 1ns/1ps
module fbd_host
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                clk_en,
  input  wire logic                req_valid,
  output      logic                req_ready,
  input  wire fbd_pkg::fbd_req_type req,
  output      logic                rsp_valid,
  output      logic [15:0]         rsp_data,
  output      fbd_pkg::fbd_pins_type pins,
  input  wire logic [15:0]         dq_i,
  output      logic [15:0]         dq_o,
  output      logic [15:0]         dq_oe,
  input  wire logic                ready_busy_n,
  output      logic                flash_ready
);
  import fbd_pkg::*;

  fbd_state_type  state_r;
  fbd_state_type  state_nxt;
  fbd_req_type    cur_r;
  fbd_pins_type   pins_r;
  fbd_pins_type   pins_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [15:0]    dq_o_r;
  logic [15:0]    dq_oe_r;
  logic [15:0]    dq_o_nxt;
  logic [15:0]    dq_oe_nxt;
  logic [15:0]    rsp_data_r;
  logic           rsp_valid_r;
  logic [2:0]     rb_sync_r;
  logic           rb_stable_r;

  wire cnt_done  = (cnt_r == CNT_ZERO);
  wire is_read   = (cur_r.op == OP_READ);
  wire is_prot   = (cur_r.op == OP_PROTECT);
  wire is_reset  = (cur_r.op == OP_RESET);
  wire take      = req_valid && (state_r == ST_IDLE);
  // Byte mode narrows the bus; pin 15 carries the low address bit
  wire [15:0] byte_oe = {1'b1, 7'h00, 8'hff};
  wire [15:0] wide_dq = req.byte_mode ? {req.byte_lsb, 7'h00, req.wdata[7:0]}
                                      : req.wdata;
  wire [15:0] rd_oe   = req.byte_mode ? {1'b1, 15'h0000} : 16'h0000;
  wire [18:0] prot_addr = {req.addr[18:7], req.unprotect, req.addr[5:2], 2'b10};
  wire [15:0] rd_mask = cur_r.byte_mode ? 16'h00ff : 16'hffff;

  assign req_ready = (state_r == ST_IDLE) && clk_en;
  assign pins      = pins_r;
  assign dq_o      = dq_o_r;
  assign dq_oe     = dq_oe_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data  = rsp_data_r;
  assign flash_ready = rb_stable_r;

  always_comb
  begin
    state_nxt = state_r;
    pins_nxt  = pins_r;
    cnt_nxt   = cnt_done ? cnt_r : cnt_r - 1'b1;
    dq_o_nxt  = dq_o_r;
    dq_oe_nxt = dq_oe_r;
    case (state_r)
      ST_IDLE:
      begin
        if (take)
        begin
          pins_nxt.byte_sel_n = ~req.byte_mode;
          pins_nxt.addr       = (req.op == OP_PROTECT) ? prot_addr : req.addr;
          cnt_nxt   = fbd_cyc(ACCESS_CYC);
          state_nxt = ST_SETUP;
          case (req.op)
            OP_READ:
            begin
              pins_nxt.chip_sel_n = 1'b0;
              pins_nxt.out_en_n   = 1'b0;
              pins_nxt.wr_en_n    = 1'b1;
              dq_o_nxt  = {req.byte_lsb, 15'h0000};
              dq_oe_nxt = rd_oe;
            end
            OP_RESET:
            begin
              pins_nxt.reset_n = 1'b0;
              pins_nxt.chip_sel_n = 1'b1;
              cnt_nxt   = fbd_cyc(RESET_CYC);
              state_nxt = ST_RST;
            end
            default:
            begin
              pins_nxt.chip_sel_n = 1'b0;
              pins_nxt.out_en_n   = 1'b1;
              pins_nxt.elevated_voltage_level = (req.op == OP_PROTECT);
              dq_o_nxt  = wide_dq;
              dq_oe_nxt = req.byte_mode ? byte_oe : 16'hffff;
              cnt_nxt   = fbd_cyc(WRITE_CYC);
            end
          endcase
        end
      end
      ST_SETUP:
      begin
        if (!is_read)
          pins_nxt.wr_en_n = 1'b0;
        state_nxt = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (cnt_done)
        begin
          pins_nxt.wr_en_n  = 1'b1;
          pins_nxt.out_en_n = 1'b1;
          state_nxt = ST_DONE;
        end
      end
      ST_DONE:
      begin
        pins_nxt.chip_sel_n = 1'b1;
        pins_nxt.elevated_voltage_level = 1'b0;
        dq_oe_nxt = 16'h0000;
        state_nxt = ST_IDLE;
      end
      ST_RST:
      begin
        dq_oe_nxt = 16'h0000;
        if (cnt_done)
        begin
          pins_nxt.reset_n = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= CNT_ZERO;
      pins_r  <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1, reset_n: 1'b1,
                   elevated_voltage_level: 1'b0, byte_sel_n: 1'b1, addr: ADDR_RST};
      dq_o_r  <= DATA_RST;
      dq_oe_r <= DATA_RST;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pins_r  <= pins_nxt;
      dq_o_r  <= dq_o_nxt;
      dq_oe_r <= dq_oe_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      cur_r <= '0;
    else if (clk_en && take)
      cur_r <= req;
  end

  // Read data is sampled at the end of the access time
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= DATA_RST;
    end
    else if (clk_en)
    begin
      rsp_valid_r <= (state_r == ST_HOLD) && cnt_done && !is_reset && !is_prot;
      if ((state_r == ST_HOLD) && cnt_done && is_read)
        rsp_data_r <= dq_i & rd_mask;
    end
  end

  // Busy pin synchroniser; change accepted when last two stages agree
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rb_sync_r   <= 3'b111;
      rb_stable_r <= 1'b1;
    end
    else if (clk_en)
    begin
      rb_sync_r <= {rb_sync_r[1:0], ready_busy_n};
      if (rb_sync_r[2] == rb_sync_r[1])
        rb_stable_r <= rb_sync_r[1];
    end
  end

endmodule : fbd_host

// >>> fbd_host_monitor.sv
`timescale 1ns/1ps
module fbd_host_chk
  import fbd_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  input wire logic                  clk_en,
  input wire logic                  req_valid,
  input wire logic                  req_ready,
  input wire fbd_pkg::fbd_req_type  req,
  input wire logic                  rsp_valid,
  input wire fbd_pkg::fbd_pins_type pins,
  input wire logic [15:0]           dq_oe
);
  default clocking @(posedge clk_sys); endclocking
  // A frozen clock enable stretches every phase, so all checks stand down
  default disable iff (!rstn || !clk_en);
  rd_ctl_a: assert property (!pins.out_en_n |-> !pins.chip_sel_n && pins.wr_en_n)
    else $error("bad read levels");
  wr_ctl_a: assert property (!pins.wr_en_n |-> !pins.chip_sel_n && pins.out_en_n)
    else $error("bad write levels");
  byte_lsb_a: assert property (!pins.byte_sel_n && !pins.out_en_n |-> dq_oe[15])
    else $error("low address bit not driven");
  prot_addr_a: assert property (pins.elevated_voltage_level && !pins.wr_en_n |-> pins.addr[1:0] == 2'h2)
    else $error("bad protect address");
  rd_answer_a: assert property (req_valid && req_ready && req.op == OP_READ |-> ##16 rsp_valid)
    else $error("read answer off time");
endmodule : fbd_host_chk

bind fbd_host fbd_host_chk chk_u (.clk_sys, .rstn, .clk_en, .req_valid, .req_ready, .req, .rsp_valid, .pins, .dq_oe);

// >>> fbd_flash_model.sv
`timescale 1ns/1ps
module fbd_flash_model
  import fbd_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire fbd_pkg::fbd_pins_type pins,
  input  wire logic [15:0]           dq_wire,
  output      logic [15:0]           dq_dev,
  output      logic                  ready_busy_n
);
  logic [15:0] noise_r = 16'h1234;
  logic [15:0] word_val;
  logic        rd_en;
  logic [18:0] cmd_addr_r;
  logic [15:0] cmd_data_r;
  logic        prot_seen_r;
  logic        prot_a6_r;
  logic [3:0]  busy_cnt_r = 4'h0;
  // Short busy window after each latched write stands in for an algorithm
  assign ready_busy_n = (busy_cnt_r == 4'h0);
  assign rd_en = pins.reset_n && !pins.elevated_voltage_level && !pins.chip_sel_n && !pins.out_en_n
    && pins.wr_en_n;
  assign word_val = {pins.addr[7:0], ~pins.addr[7:0]};
  // Released pins show a toggling pattern
  assign dq_dev = !rd_en ? noise_r : pins.byte_sel_n ? word_val
    : {noise_r[15:8], dq_wire[15] ? word_val[15:8] : word_val[7:0]};
  always @(posedge clk_sys)
  begin
    noise_r <= ~noise_r;
    if (busy_cnt_r != 4'h0)
      busy_cnt_r <= busy_cnt_r - 4'h1;
    if (!pins.reset_n && !pins.elevated_voltage_level)
      cmd_data_r <= 16'h0000;
    else if (!pins.chip_sel_n && !pins.wr_en_n && pins.out_en_n)
    begin
      cmd_addr_r  <= pins.addr;
      cmd_data_r  <= dq_wire;
      prot_seen_r <= pins.elevated_voltage_level;
      prot_a6_r   <= pins.addr[6];
      busy_cnt_r  <= 4'h8;
    end
  end
endmodule : fbd_flash_model

// >>> test_flash_bus_operation_decode.sv
`timescale 1ns/1ps
module test_flash_bus_operation_decode;
  import fbd_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rstn = 1'b0;
  logic         clk_en = 1'b1;
  logic         req_valid = 1'b0;
  logic         req_ready, rsp_valid, flash_ready, ready_busy_n;
  fbd_req_type  req = '0;
  fbd_pins_type pins;
  logic [15:0]  rsp_data, dq_o, dq_oe, dq_dev, dq_wire, g;
  int           num_errors = 0;
  int           checked = 0;
  assign dq_wire = (dq_oe & dq_o) | (~dq_oe & dq_dev);
  fbd_host dut_u (.clk_sys, .rstn, .clk_en, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data, .pins,
    .dq_i(dq_wire), .dq_o, .dq_oe, .ready_busy_n, .flash_ready);
  fbd_flash_model mdl_u (.clk_sys, .pins, .dq_wire, .dq_dev, .ready_busy_n);
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic run(input fbd_req_type r);
    bit seen;
    seen = 1'b0;
    while (req_ready !== 1'b1) @(posedge clk_sys) #1;
    req = r;
    req_valid = 1'b1;
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
    do
    begin
      @(posedge clk_sys) #1;
      if (rsp_valid === 1'b1)
      begin
        g = rsp_data;
        seen = 1'b1;
      end
    end while (req_ready !== 1'b1 || (r.op <= OP_WRITE && !seen));
  endtask : run
  task automatic t_write;
    run('{OP_WRITE, 1'b0, 1'b0, 1'b0, 19'h2aaaa, 16'h00a5});
    cmp("cmd data", 16'h00a5, mdl_u.cmd_data_r);
    cmp("cmd addr", 16'haaaa, mdl_u.cmd_addr_r[15:0]);
    cmp("busy pin", 16'h0000, {15'h0, flash_ready});
    run('{OP_READ, 1'b0, 1'b0, 1'b0, 19'h7ff45, 16'h0000});
    cmp("word", 16'h45ba, g);
    $display("write done");
  endtask : t_write
  task automatic t_byte;
    for (int i = 0; i < 2; i++)
    begin
      run('{OP_READ, 1'b1, i[0], 1'b0, 19'h00033, 16'h0000});
      cmp("byte", i[0] ? 16'h0033 : 16'h00cc, g);
    end
    $display("byte done");
  endtask : t_byte
  task automatic t_protect;
    for (int i = 0; i < 2; i++)
    begin
      run('{OP_PROTECT, 1'b0, 1'b0, i[0], 19'h40000, 16'h0000});
      cmp("protect", {13'h0, i[0], 2'h2}, {13'h0, mdl_u.prot_a6_r, mdl_u.cmd_addr_r[1:0]});
      cmp("elevated", 16'h0001, {15'h0, mdl_u.prot_seen_r});
    end
    $display("protect done");
  endtask : t_protect
  task automatic t_reset;
    run('{OP_WRITE, 1'b0, 1'b0, 1'b0, 19'h00100, 16'h0055});
    run('{OP_RESET, 1'b0, 1'b0, 1'b0, 19'h00000, 16'h0000});
    cmp("cmd cleared", 16'h0000, mdl_u.cmd_data_r);
    run('{OP_READ, 1'b0, 1'b0, 1'b0, 19'h00001, 16'h0000});
    cmp("after reset", 16'h01fe, g);
    cmp("ready pin", 16'h0001, {15'h0, flash_ready});
    $display("reset done");
  endtask : t_reset
  task automatic t_freeze;
    int n;
    n = 0;
    while (req_ready !== 1'b1) @(posedge clk_sys) #1;
    req = '{OP_READ, 1'b0, 1'b0, 1'b0, 19'h00077, 16'h0000};
    req_valid = 1'b1;
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
    repeat (3) @(posedge clk_sys) #1;
    clk_en = 1'b0;
    repeat (20) @(posedge clk_sys) #1;
    cmp("frozen oe", 16'h0000, {15'h0, pins.out_en_n});
    cmp("frozen rsp", 16'h0000, {15'h0, rsp_valid});
    clk_en = 1'b1;
    do
    begin
      @(posedge clk_sys) #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    cmp("freeze cycles", 16'(ACCESS_CYC - 3), 16'(n));
    cmp("freeze data", 16'h7788, rsp_data);
    $display("freeze done");
  endtask : t_freeze
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial forever #5 clk_sys = ~clk_sys;
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 rstn = 1'b1;
    t_write();
    t_byte();
    t_protect();
    t_reset();
    t_freeze();
    print_verdict();
  end
endmodule : test_flash_bus_operation_decode
